// ===== verification/bch_cfg_hdr_bench.sv
`timescale 1ns/1ps
module bch_cfg_hdr_bench;
  localparam [7:0] REV = 8'h5a; // Arbitrary value
  reg         clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rev = 0, trn = 1, spci = 1;
  reg  [7:0]  pa = 0;
  reg  [31:0] pd = 0;
  reg  [3:0]  ps = 0;
  wire        rdy, err;
  wire [31:0] rd;
  integer     errors = 0, total_checks = 0, n;
  bch_cfg_hdr #(.REVISION(REV)) bch_cfg_hdr_i (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pd), .PSTRB_I(ps), .PREADY_O(rdy), .PRDATA_O(rd), .PSLVERR_O(err),
    .REVERSE_I(rev), .TRANSPARENT_I(trn), .SEC_PCI_MODE_I(spci), .CACHE_LINE_O(), .PRI_LATENCY_O(),
    .PRI_BUS_O(), .SEC_BUS_O(), .SUB_BUS_O(), .SEC_LATENCY_O());
  initial begin
    forever #4 clk = ~clk;
  end
  // One APB transfer; compares error flag and read data
  task t(input w, input [7:0] a, input [31:0] d, input [3:0] s, input [32:0] e);
    begin
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pd <= d;
      ps <= s;
      @(posedge clk);
      pen <= 1;
      n = 0;
      @(negedge clk);
      while (rdy !== 1'b1 && n < 9) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 9) begin
        errors = errors + 1;
        $display("CHECK FAILED ready addr %h expected 1 seen %b", a, rdy);
      end
      total_checks = total_checks + 1;
      if ({err, rd} !== e) begin
        errors = errors + 1;
        $display("CHECK FAILED addr %h expected %h seen %h", a, e, {err, rd});
      end
      @(posedge clk);
      psel <= 0;
      pen <= 0;
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t(0, 8'h08, 0, 0, {9'h006, 16'h0400, REV});
    t(0, 8'h0c, 0, 0, 33'h10000);
    t(0, 8'h18, 0, 0, 0);
    $display("reset test done");
    t(1, 8'h18, 32'h44332211, 4'h7, 0);
    t(1, 8'h18, 32'haa000000, 4'h8, 0);
    t(0, 8'h18, 0, 0, 33'haa332211);
    t(1, 8'h0c, 32'hffffffff, 4'hf, 0);
    t(0, 8'h0c, 0, 0, 33'h1003c);
    rev <= 1;
    t(1, 8'h0c, 32'hffffffff, 4'hf, 0);
    t(0, 8'h0c, 0, 0, 33'h1ff3c);
    t(1, 8'h18, 32'h55000000, 4'h8, 0);
    t(0, 8'h18, 0, 0, 33'haa332211);
    trn <= 0;
    t(0, 8'h0c, 0, 0, 33'hff3c);
    rev <= 0;
    spci <= 0;
    t(1, 8'h18, 32'h11000000, 4'h8, 0);
    t(0, 8'h18, 0, 0, 33'haa332211);
    $display("mode test done");
    t(1, 8'h10, 32'hffffffff, 4'hf, 0);
    t(0, 8'h10, 0, 0, 0);
    t(1, 8'h08, 32'hffffffff, 4'hf, 0);
    t(0, 8'h08, 0, 0, {9'h006, 16'h0400, REV});
    t(0, 8'h20, 0, 0, 33'h100000000);
    $display("reserved test done");
    complete_run;
  end
  // Watchdog well past the expected run
  initial begin
    #20000;
    errors = errors + 1;
    complete_run;
  end
endmodule

// ===== verification/bch_cfg_hdr_props.sv
`timescale 1ns/1ps
module bch_cfg_hdr_props (
  input wire        CLK_I, RESET_N_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, REVERSE_I, TRANSPARENT_I,
  input wire [7:0]  PADDR_I, PRI_LATENCY_O, PRI_BUS_O, SEC_BUS_O, SUB_BUS_O, SEC_LATENCY_O,
  input wire [31:0] PWDATA_I, PRDATA_O,
  input wire [3:0]  PSTRB_I, CACHE_LINE_O
);
  // Answer qualifiers
  wire       rd_ok = PREADY_O && !PWRITE_I;
  wire       bw    = PREADY_O && PWRITE_I && PADDR_I == 8'h18 && PSTRB_I[0];
  wire [7:0] wlo   = PWDATA_I[7:0];
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // One wait state, never more
  a_one_wait: assert property (PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O) else $error("ready late");
  a_id_bytes: assert property (rd_ok && PADDR_I == 8'h08 |-> PRDATA_O[31:8] == 24'h060400) else $error("id");
  a_hdr_layout: assert property (rd_ok && PADDR_I == 8'h0c |-> PRDATA_O[31:16] == {15'h0, TRANSPARENT_I} && PRDATA_O[7:0] == {2'h0, CACHE_LINE_O, 2'h0}) else $error("hdr");
  a_bus_mirror: assert property (rd_ok && PADDR_I == 8'h18 |-> PRDATA_O == {SEC_LATENCY_O, SUB_BUS_O, SEC_BUS_O, PRI_BUS_O}) else $error("bus rd");
  // Latency timers frozen by bridge direction: primary when forward, secondary when reverse
  a_pri_fixed: assert property (!REVERSE_I |=> $stable(PRI_LATENCY_O)) else $error("pri lat");
  a_sec_fixed: assert property (REVERSE_I |=> $stable(SEC_LATENCY_O)) else $error("sec lat");
  // Bus number follows lane 0 only
  a_bus_write: assert property (bw |=> PRI_BUS_O == $past(wlo)) else $error("bus wr");
  a_bus_hold: assert property (!bw |=> $stable(PRI_BUS_O)) else $error("bus hold");
  a_rsvd_zero: assert property (PREADY_O && (PADDR_I == 8'h10 || PADDR_I == 8'h14) |-> PRDATA_O == 32'h0 && !PSLVERR_O) else $error("rsvd");
  c_rev_wr: cover property (PREADY_O && PWRITE_I && REVERSE_I);
  c_err: cover property (PSLVERR_O);
  c_bus: cover property (bw);
endmodule
bind bch_cfg_hdr bch_cfg_hdr_props bch_cfg_hdr_props_i (.*);

// ===== verilog/bch_cfg_hdr.v
`timescale 1ns/1ps
`include "bch_cfg_map.vh"

module bch_cfg_hdr #(
  parameter [7:0] REVISION = 8'h01  // Arbitrary value, set per silicon step
) (
  // Clock and reset
  input  wire        CLK_I,
  input  wire        RESET_N_I,
  // APB slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  input  wire [3:0]  PSTRB_I,
  output wire        PREADY_O,
  output wire [31:0] PRDATA_O,
  output wire        PSLVERR_O,
  // Bridge operating mode
  input  wire        REVERSE_I,
  input  wire        TRANSPARENT_I,
  input  wire        SEC_PCI_MODE_I,
  // Register contents to the bridge
  output wire [3:0]  CACHE_LINE_O,
  output wire [7:0]  PRI_LATENCY_O,
  output wire [7:0]  PRI_BUS_O,
  output wire [7:0]  SEC_BUS_O,
  output wire [7:0]  SUB_BUS_O,
  output wire [7:0]  SEC_LATENCY_O
);

  // Stored register fields
  reg  [3:0]  cls_r;
  reg  [7:0]  pri_lat_r;
  reg  [7:0]  pri_bus_r;
  reg  [7:0]  sec_bus_r;
  reg  [7:0]  sub_bus_r;
  reg  [7:0]  sec_lat_r;

  // Their next values
  reg  [3:0]  cls_nxt;
  reg  [7:0]  pri_lat_nxt;
  reg  [7:0]  pri_bus_nxt;
  reg  [7:0]  sec_bus_nxt;
  reg  [7:0]  sub_bus_nxt;
  reg  [7:0]  sec_lat_nxt;

  // Bus answer flops and their next values
  reg         pready_r;
  reg  [31:0] prdata_r;
  reg         pslverr_r;
  reg         pready_nxt;
  reg  [31:0] prdata_nxt;
  reg         pslverr_nxt;

  // Read mux result
  reg  [31:0] rd_nxt;

  // Handshake qualifiers
  wire        acc_phase;
  wire        first_acc;
  wire        wr_go;
  wire        rd_go;

  // Address decode
  wire        hit_class;
  wire        hit_hdr;
  wire        hit_rsvd;
  wire        hit_bus;
  wire        hit_any;

  // Mode-dependent writability
  wire        pri_lat_wr;
  wire        sec_lat_wr;

  // Write enables per field
  wire        cls_we;
  wire        pri_lat_we;
  wire [3:0]  bus_lane_ok;
  wire [3:0]  bus_lane_we;

  // Assembled read words
  wire [6:0]  hdr_type;
  wire [7:0]  cls_byte;
  wire [7:0]  hdr_byte;
  wire [31:0] class_word;
  wire [31:0] hdr_word;
  wire [31:0] bus_word;

  // Loop index for the byte lanes
  genvar      lane;

  // Access phase of a selected transfer
  assign acc_phase = PSEL_I & PENABLE_I;

  // First access edge; ready is raised for the edge after it
  // Exactly one wait state, the bridge side never stalls here
  // Back-to-back setup after ready drops penable, so no double answer
  assign first_acc = acc_phase & ~pready_r;

  // A write lands only at the edge where ready stands
  assign wr_go = acc_phase & pready_r & PWRITE_I;

  // Read data captured one edge early so it stands with ready
  assign rd_go = first_acc & ~PWRITE_I;

  // Full byte compare, so a misaligned address counts as unmapped
  // Offsets 10h and 14h decode as mapped but hold no storage
  assign hit_class = (PADDR_I == `BCH_OFS_CLASS_REV);
  assign hit_hdr   = (PADDR_I == `BCH_OFS_HDR_LAT_CLS);
  assign hit_rsvd  = (PADDR_I == `BCH_OFS_RSVD_LO) | (PADDR_I == `BCH_OFS_RSVD_HI);
  assign hit_bus   = (PADDR_I == `BCH_OFS_BUS_NUMS);
  assign hit_any   = hit_class | hit_hdr | hit_rsvd | hit_bus;

  // Forward bridge freezes the primary timer, reverse the secondary
  // Stored values survive a mode change; only writes are blocked
  assign pri_lat_wr = REVERSE_I;
  assign sec_lat_wr = ~REVERSE_I & SEC_PCI_MODE_I;

  // Reverse primary side is taken as conventional PCI, so no extra gate;
  // a primary bus mode input would slot in beside REVERSE_I
  // if a part ever offers the reverse bridge without it.

  // Cache line lane; only bits 5:2 have storage
  // Other bits of the lane are dropped on the floor
  assign cls_we = wr_go & hit_hdr & PSTRB_I[0];

  // Primary latency lane, dropped while the timer is read-only
  // Lanes 2 and 3 of this word are fixed and never written
  assign pri_lat_we = wr_go & hit_hdr & PSTRB_I[1] & pri_lat_wr;

  // Lane gates of the bus number word; only the top lane depends on mode
  // Bus numbers themselves are always writable
  assign bus_lane_ok = {sec_lat_wr, 3'h7};

  // One write enable per byte lane of the bus number word
  // Lanes are independent so software may update one number alone
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_bus_lane
      assign bus_lane_we[lane] = wr_go & hit_bus & PSTRB_I[lane] & bus_lane_ok[lane];
    end
  endgenerate

  // Header layout follows transparency
  // Endpoint layout is reported in non-transparent mode
  assign hdr_type = TRANSPARENT_I ? `BCH_HDR_TYPE_BRIDGE : `BCH_HDR_TYPE_ENDPT;

  // Unimplemented cache line bits read as zero
  // No flops behind them, so nothing to clear at reset
  assign cls_byte = {2'h0, cls_r, 2'h0};

  // Single function flag above the layout code
  // Constant zero; no multi-function decode exists
  assign hdr_byte = {`BCH_MULTI_FUNC, hdr_type};

  // Identification word: all constants, nothing to store
  // Revision comes from the parameter, one value per silicon step
  assign class_word = {`BCH_BASE_CLASS, `BCH_SUB_CLASS, `BCH_PROG_IF, REVISION};

  // Header word; top byte is reserved and reads zero
  // Latency byte shows the stored value in either direction
  assign hdr_word = {8'h00, hdr_byte, pri_lat_r, cls_byte};

  // Bus number word
  // Secondary latency byte reads back even while frozen
  assign bus_word = {sec_lat_r, sub_bus_r, sec_bus_r, pri_bus_r};

  // Read mux; reserved words answer zero without an error
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (PADDR_I)
      // Identification
      `BCH_OFS_CLASS_REV: begin
        rd_nxt = class_word;
      end
      // Cache line, latency and layout
      `BCH_OFS_HDR_LAT_CLS: begin
        rd_nxt = hdr_word;
      end
      // Reserved pair
      `BCH_OFS_RSVD_LO, `BCH_OFS_RSVD_HI: begin
        rd_nxt = 32'h0000_0000;
      end
      // Bus numbers and secondary latency
      `BCH_OFS_BUS_NUMS: begin
        rd_nxt = bus_word;
      end
      // Outside this header window
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  // Next ready pulse, error flag and read data
  // Read data is forced to zero outside its answer so stale words never linger
  always @* begin
    pready_nxt  = first_acc;
    pslverr_nxt = first_acc & ~hit_any;
    prdata_nxt  = 32'h0000_0000;
    if (rd_go) begin
      prdata_nxt = rd_nxt;
    end
  end

  // Cache line bits hold unless lane 0 is written
  // One-hot use is up to software; any pattern is stored
  always @* begin
    if (cls_we) begin
      cls_nxt = PWDATA_I[`BCH_CLS_MSB:`BCH_CLS_LSB];
    end else begin
      cls_nxt = cls_r;
    end
  end

  // Primary latency timer next value
  // Holds whenever the timer is read-only
  always @* begin
    if (pri_lat_we) begin
      pri_lat_nxt = PWDATA_I[15:8];
    end else begin
      pri_lat_nxt = pri_lat_r;
    end
  end

  // Primary bus number next value
  // Lane 0 of the bus number word
  always @* begin
    if (bus_lane_we[0]) begin
      pri_bus_nxt = PWDATA_I[7:0];
    end else begin
      pri_bus_nxt = pri_bus_r;
    end
  end

  // Secondary bus number next value
  // Lane 1 of the bus number word
  always @* begin
    if (bus_lane_we[1]) begin
      sec_bus_nxt = PWDATA_I[15:8];
    end else begin
      sec_bus_nxt = sec_bus_r;
    end
  end

  // Subordinate bus number next value
  // Lane 2 of the bus number word
  always @* begin
    if (bus_lane_we[2]) begin
      sub_bus_nxt = PWDATA_I[23:16];
    end else begin
      sub_bus_nxt = sub_bus_r;
    end
  end

  // Secondary latency timer next value
  // Lane 3, gated by the bridge direction and SEC_PCI_MODE_I
  always @* begin
    if (bus_lane_we[3]) begin
      sec_lat_nxt = PWDATA_I[31:24];
    end else begin
      sec_lat_nxt = sec_lat_r;
    end
  end

  // Bus answer flops
  // Ready is a one-cycle pulse; error and data stand with it only
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Cache line storage
  // Cleared by reset, so no line size is selected until software sets one
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cls_r <= `BCH_RST_CLS;
    end else begin
      cls_r <= cls_nxt;
    end
  end

  // Primary latency storage
  // Reset value is also what a forward bridge keeps reading
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pri_lat_r <= `BCH_RST_BYTE;
    end else begin
      pri_lat_r <= pri_lat_nxt;
    end
  end

  // Primary bus number storage
  // Enumeration software fills it after reset
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pri_bus_r <= `BCH_RST_BYTE;
    end else begin
      pri_bus_r <= pri_bus_nxt;
    end
  end

  // Secondary bus number storage
  // Cleared so no bus is claimed before enumeration
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sec_bus_r <= `BCH_RST_BYTE;
    end else begin
      sec_bus_r <= sec_bus_nxt;
    end
  end

  // Subordinate bus number storage
  // Cleared together with the secondary number
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sub_bus_r <= `BCH_RST_BYTE;
    end else begin
      sub_bus_r <= sub_bus_nxt;
    end
  end

  // Secondary latency storage
  // Same reset value in both directions
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sec_lat_r <= `BCH_RST_BYTE;
    end else begin
      sec_lat_r <= sec_lat_nxt;
    end
  end

  // Bus answer outputs straight from flops
  assign PREADY_O      = pready_r;
  assign PRDATA_O      = prdata_r;
  assign PSLVERR_O     = pslverr_r;

  // Field contents to the bridge, straight from flops
  assign CACHE_LINE_O  = cls_r;
  assign PRI_LATENCY_O = pri_lat_r;
  assign PRI_BUS_O     = pri_bus_r;
  assign SEC_BUS_O     = sec_bus_r;
  assign SUB_BUS_O     = sub_bus_r;
  assign SEC_LATENCY_O = sec_lat_r;

endmodule

// ===== verilog/bch_cfg_map.vh
`ifndef BCH_CFG_MAP_VH
`define BCH_CFG_MAP_VH

// Dword byte addresses of the header window
`define BCH_OFS_CLASS_REV    8'h08
`define BCH_OFS_HDR_LAT_CLS  8'h0c
`define BCH_OFS_RSVD_LO      8'h10
`define BCH_OFS_RSVD_HI      8'h14
`define BCH_OFS_BUS_NUMS     8'h18

// Fixed identification values
`define BCH_PROG_IF          8'h00
`define BCH_SUB_CLASS        8'h04
`define BCH_BASE_CLASS       8'h06
`define BCH_HDR_TYPE_BRIDGE  7'h01
`define BCH_HDR_TYPE_ENDPT   7'h00
`define BCH_MULTI_FUNC       1'h0

// Field positions
`define BCH_CLS_LSB          2
`define BCH_CLS_MSB          5

// Reset values
`define BCH_RST_BYTE         8'h00
`define BCH_RST_CLS          4'h0

`endif
